// ### mcr_params.svh
/*
 Register offsets, field positions and counts for one logic array block of
 configurable macrocell registers.
 Assumes it is included by its bare name, once per compilation unit.
*/
// What this block does
// - Per-macrocell D, T, JK or SR type
// - Bypass option gives combinational output
// - Mode one: global clock, no enable
// - Mode two: global clock gated by enable
// - Mode three: product-term array clock
// - Two global clocks, true/inverted, either pin
// - Asynchronous preset and clear from product terms
// - Product-term preset and clear are active high
// - Clear selectable from global clear pin
// - Global clear has programmable polarity
// - Packing: one term to D, rest combinational
// - Each output drives global or local routing
// - Each I/O register has clock enable
// - Sixteen macrocells form one block
// - Expanders give up to 32 terms
// - Four dedicated global control inputs
// - Five dedicated product terms per macrocell
`ifndef MCR_PARAMS_SVH
`define MCR_PARAMS_SVH

`define MCR_CELLS 16
`define MCR_OWN_TERMS 5
`define MCR_EXP_TERMS 27
`define MCR_DATA_RESET 32'h0000_0000

`define MCR_OFF_CFG_BASE 12'h000
`define MCR_OFF_EXP_BASE 12'h080
`define MCR_OFF_GLOBAL 12'h100
`define MCR_OFF_REG_STATE 12'h104
`define MCR_OFF_COMB_STATE 12'h108
`define MCR_OFF_PINS 12'h10C
`define MCR_OFF_IO_DIR 12'h110
`define MCR_OFF_IO_CE 12'h114
`define MCR_BANK_CFG 6'h00
`define MCR_BANK_EXP 6'h02

`define MCR_CFG_W 11
`define MCR_CFG_TYPE_LO 0
`define MCR_CFG_TYPE_HI 1
`define MCR_CFG_BYPASS 2
`define MCR_CFG_MODE_LO 3
`define MCR_CFG_MODE_HI 4
`define MCR_CFG_GCLK_SEL 5
`define MCR_CFG_GCLR_EN 6
`define MCR_CFG_PACK 7
`define MCR_CFG_GLOB_COMB 8
`define MCR_CFG_LOCAL_COMB 9
`define MCR_CFG_EXP_EN 10

`define MCR_GLB_W 6
`define MCR_GLB_G0_SRC 0
`define MCR_GLB_G0_INV 1
`define MCR_GLB_G1_SRC 2
`define MCR_GLB_G1_INV 3
`define MCR_GLB_CLR_POL 4
`define MCR_GLB_IO_GATE 5

`define MCR_PT_PACK_D 0
`define MCR_PT_SECOND 1

`endif

// ### mcr_pkg.sv
/*
 Types shared by the macrocell block: flip-flop type and clocking mode.
 Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package mcr_pkg;
    typedef enum logic [1:0] {
        MCR_FF_D = 2'b00,
        MCR_FF_T = 2'b01,
        MCR_FF_JK = 2'b10,
        MCR_FF_SR = 2'b11
    } mcr_ff_type;
    typedef enum logic [1:0] {
        MCR_CLK_GLOBAL = 2'b00,
        MCR_CLK_GLOBAL_EN = 2'b01,
        MCR_CLK_ARRAY = 2'b10,
        MCR_CLK_SPARE = 2'b11
    } mcr_clk_mode_type;
endpackage
`default_nettype wire

// ### mcr_macrocell_lab.sv
/*
 One logic array block of sixteen configurable macrocell registers with
 their I/O cell registers, configured over an APB slave.
 Assumes product terms come from logic on clk; dedicated and I/O pins are
 asynchronous and are synchronised here. Clock pins are sampled, so their
 edges must be slower than a few periods of clk.
*/
// Decided for this implementation: register access over APB and the address map.
`include "mcr_params.svh"
`default_nettype none
module mcr_macrocell_lab (
    input wire logic clk, // System clock, 25 MHz.
    input wire logic rst_n, // Asynchronous reset, active low.
    input wire logic psel, // APB select.
    input wire logic penable, // APB enable.
    input wire logic pwrite, // APB write direction.
    input wire logic [11:0] paddr, // APB byte address.
    input wire logic [31:0] pwdata, // APB write data.
    output logic [31:0] prdata, // APB read data.
    output logic pready, // APB ready.
    output logic pslverr, // APB error for an unmapped address.
    input wire logic global_clock_pin_a, // Dedicated global clock pin A.
    input wire logic global_clock_pin_b, // Dedicated global clock pin B.
    input wire logic global_clear_pin, // Dedicated global clear pin.
    input wire logic global_ctrl_pin_d, // Fourth dedicated control pin.
    input wire logic [79:0] product_terms, // Five terms per macrocell.
    input wire logic [26:0] expander_terms, // Shared expander term pool.
    input wire logic [15:0] array_clock_term, // Product-term clock per cell.
    input wire logic [15:0] clock_enable_term, // Clock enable per cell.
    input wire logic [15:0] preset_term, // Preset term per cell, high.
    input wire logic [15:0] clear_term, // Clear term per cell, high.
    input wire logic [15:0] io_data_in, // I/O pin input levels.
    output logic [15:0] reg_out, // Registered output per cell.
    output logic [15:0] comb_out, // Combinational output per cell.
    output logic [15:0] global_route_out, // Drive onto global routing.
    output logic [15:0] logic_array_block_out, // Drive onto local array.
    output logic [15:0] io_reg_out // I/O cell register outputs.
);
    logic [`MCR_CFG_W-1:0] cfg_ff [`MCR_CELLS];
    logic [`MCR_EXP_TERMS-1:0] exp_mask_ff [`MCR_CELLS];
    logic [`MCR_GLB_W-1:0] glb_ff;
    logic [15:0] io_dir_ff;
    logic [15:0] io_ce_ff;
    logic [3:0] pin_s1_ff;
    logic [3:0] pin_s2_ff;
    logic [15:0] io_s1_ff;
    logic [15:0] io_s2_ff;
    logic [1:0] gclk_prev_ff;
    logic [15:0] aclk_prev_ff;
    logic [15:0] q_ff;
    logic [15:0] comb_ff;
    logic [15:0] glob_ff;
    logic [15:0] local_ff;
    logic [15:0] io_reg_ff;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic [1:0] gclk_lvl;
    logic [1:0] gclk_rise;
    logic [15:0] aclk_rise;
    logic gclr_active;
    logic [15:0] func_val;
    logic [15:0] first_in;
    logic [15:0] second_in;
    logic [15:0] clk_event;
    logic [15:0] clr_val;
    logic [15:0] nxt_q;
    logic [15:0] nxt_comb;
    logic [15:0] nxt_reg;
    logic [31:0] nxt_prdata;
    logic nxt_pslverr;
    logic setup_phase;
    logic wr_take;
    logic [5:0] bank;
    logic [3:0] cell_idx;

    // Next flip-flop state for the configured type.
    function automatic logic mcr_next(input mcr_pkg::mcr_ff_type t, input logic q,
                                      input logic a, input logic b);
        logic r;
        r = q;
        case (t)
            mcr_pkg::MCR_FF_D: r = a;
            mcr_pkg::MCR_FF_T: r = q ^ a;
            mcr_pkg::MCR_FF_JK: begin
                if (a && b) begin
                    r = ~q;
                end else if (a) begin
                    r = 1'b1;
                end else if (b) begin
                    r = 1'b0;
                end
            end
            mcr_pkg::MCR_FF_SR: begin
                // Reset wins when set and reset are both high.
                if (b) begin
                    r = 1'b0;
                end else if (a) begin
                    r = 1'b1;
                end
            end
            default: r = q;
        endcase
        return r;
    endfunction

    // Global clock level from a chosen pin, true or inverted.
    function automatic logic mcr_gclk(input logic src, input logic inv, input logic pa,
                                      input logic pb);
        return (src ? pb : pa) ^ inv;
    endfunction

    // Dedicated pins pass two flip-flops before use.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1_ff <= 4'h0;
            pin_s2_ff <= 4'h0;
            io_s1_ff <= 16'h0000;
            io_s2_ff <= 16'h0000;
        end else begin
            pin_s1_ff <= {global_ctrl_pin_d, global_clear_pin, global_clock_pin_b,
                          global_clock_pin_a};
            pin_s2_ff <= pin_s1_ff;
            io_s1_ff <= io_data_in;
            io_s2_ff <= io_s1_ff;
        end
    end

    always_comb begin
        gclk_lvl[0] = mcr_gclk(glb_ff[`MCR_GLB_G0_SRC], glb_ff[`MCR_GLB_G0_INV],
                               pin_s2_ff[0], pin_s2_ff[1]);
        gclk_lvl[1] = mcr_gclk(glb_ff[`MCR_GLB_G1_SRC], glb_ff[`MCR_GLB_G1_INV],
                               pin_s2_ff[0], pin_s2_ff[1]);
        gclk_rise = gclk_lvl & ~gclk_prev_ff;
        aclk_rise = array_clock_term & ~aclk_prev_ff;
        gclr_active = glb_ff[`MCR_GLB_CLR_POL] ? pin_s2_ff[2] : ~pin_s2_ff[2];
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gclk_prev_ff <= 2'b00;
            aclk_prev_ff <= 16'h0000;
        end else begin
            gclk_prev_ff <= gclk_lvl;
            aclk_prev_ff <= array_clock_term;
        end
    end

    // Logic function, flip-flop inputs and clock events for each macrocell.
    always_comb begin
        func_val = 16'h0000;
        first_in = 16'h0000;
        second_in = 16'h0000;
        clk_event = 16'h0000;
        clr_val = 16'h0000;
        nxt_q = q_ff;
        nxt_comb = 16'h0000;
        nxt_reg = 16'h0000;
        for (int i = 0; i < `MCR_CELLS; i++) begin
            logic [`MCR_OWN_TERMS-1:0] pt;
            logic expv;
            logic packed_rest;
            logic use_pack;
            pt = product_terms[i*`MCR_OWN_TERMS +: `MCR_OWN_TERMS];
            expv = cfg_ff[i][`MCR_CFG_EXP_EN] && |(expander_terms & exp_mask_ff[i]);
            use_pack = cfg_ff[i][`MCR_CFG_PACK];
            func_val[i] = |pt | expv;
            packed_rest = |(pt & ~(5'h01 << `MCR_PT_PACK_D)) | expv;
            if (use_pack) begin
                first_in[i] = pt[`MCR_PT_PACK_D];
                second_in[i] = 1'b0;
                nxt_comb[i] = packed_rest;
            end else begin
                first_in[i] = |(pt & ~(5'h01 << `MCR_PT_SECOND)) | expv;
                second_in[i] = pt[`MCR_PT_SECOND];
                nxt_comb[i] = func_val[i];
            end
            if (cfg_ff[i][`MCR_CFG_TYPE_HI:`MCR_CFG_TYPE_LO] < 2'b10) begin
                first_in[i] = use_pack ? pt[`MCR_PT_PACK_D] : func_val[i];
            end
            case (mcr_pkg::mcr_clk_mode_type'(cfg_ff[i][`MCR_CFG_MODE_HI:`MCR_CFG_MODE_LO]))
                mcr_pkg::MCR_CLK_GLOBAL_EN:
                    clk_event[i] = gclk_rise[cfg_ff[i][`MCR_CFG_GCLK_SEL]]
                                   && clock_enable_term[i];
                mcr_pkg::MCR_CLK_ARRAY: clk_event[i] = aclk_rise[i];
                default: clk_event[i] = gclk_rise[cfg_ff[i][`MCR_CFG_GCLK_SEL]];
            endcase
            clr_val[i] = clear_term[i] || (cfg_ff[i][`MCR_CFG_GCLR_EN] && gclr_active);
            if (clr_val[i]) begin
                nxt_q[i] = 1'b0;
            end else if (preset_term[i]) begin
                nxt_q[i] = 1'b1;
            end else if (clk_event[i]) begin
                nxt_q[i] = mcr_next(mcr_pkg::mcr_ff_type'(
                                    cfg_ff[i][`MCR_CFG_TYPE_HI:`MCR_CFG_TYPE_LO]),
                                    q_ff[i], first_in[i], second_in[i]);
            end
            nxt_reg[i] = cfg_ff[i][`MCR_CFG_BYPASS] ? nxt_comb[i] : nxt_q[i];
        end
    end

    // Macrocell flip-flops; preset and clear act without a clock event.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q_ff <= 16'h0000;
        end else begin
            q_ff <= nxt_q;
        end
    end

    // Dual outputs and routing choice per macrocell.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            comb_ff <= 16'h0000;
            reg_out <= 16'h0000;
            glob_ff <= 16'h0000;
            local_ff <= 16'h0000;
        end else begin
            comb_ff <= nxt_comb;
            reg_out <= nxt_reg;
            for (int i = 0; i < `MCR_CELLS; i++) begin
                glob_ff[i] <= cfg_ff[i][`MCR_CFG_GLOB_COMB] ? nxt_comb[i] : nxt_reg[i];
                local_ff[i] <= cfg_ff[i][`MCR_CFG_LOCAL_COMB] ? nxt_comb[i] : nxt_reg[i];
            end
        end
    end

    // I/O cell registers on global clock 0, each with its own enable.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            io_reg_ff <= 16'h0000;
        end else begin
            for (int i = 0; i < `MCR_CELLS; i++) begin
                if (gclk_rise[0] && io_ce_ff[i]
                    && (!glb_ff[`MCR_GLB_IO_GATE] || pin_s2_ff[3])) begin
                    io_reg_ff[i] <= io_dir_ff[i] ? q_ff[i] : io_s2_ff[i];
                end
            end
        end
    end

    assign comb_out = comb_ff;
    assign global_route_out = glob_ff;
    assign logic_array_block_out = local_ff;
    assign io_reg_out = io_reg_ff;

    // APB slave: no wait states, answer registered in the setup cycle.
    assign setup_phase = psel && !penable;
    assign wr_take = psel && penable && pready_ff && pwrite && !pslverr_ff;
    assign bank = paddr[11:6];
    assign cell_idx = paddr[5:2];

    always_comb begin
        nxt_prdata = `MCR_DATA_RESET;
        nxt_pslverr = 1'b0;
        if (paddr[1:0] != 2'b00) begin
            nxt_pslverr = 1'b1;
        end else if (bank == `MCR_BANK_CFG) begin
            nxt_prdata[`MCR_CFG_W-1:0] = cfg_ff[cell_idx];
        end else if (bank == `MCR_BANK_EXP) begin
            nxt_prdata[`MCR_EXP_TERMS-1:0] = exp_mask_ff[cell_idx];
        end else begin
            case (paddr)
                `MCR_OFF_GLOBAL: nxt_prdata[`MCR_GLB_W-1:0] = glb_ff;
                `MCR_OFF_REG_STATE: nxt_prdata[15:0] = q_ff;
                `MCR_OFF_COMB_STATE: nxt_prdata[15:0] = comb_ff;
                `MCR_OFF_PINS: nxt_prdata[3:0] = pin_s2_ff;
                `MCR_OFF_IO_DIR: nxt_prdata[15:0] = io_dir_ff;
                `MCR_OFF_IO_CE: nxt_prdata[15:0] = io_ce_ff;
                default: nxt_pslverr = 1'b1;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= `MCR_DATA_RESET;
        end else begin
            pready_ff <= setup_phase;
            if (setup_phase) begin
                pslverr_ff <= nxt_pslverr;
                prdata_ff <= pwrite ? `MCR_DATA_RESET : nxt_prdata;
            end else if (pready_ff) begin
                pslverr_ff <= 1'b0;
                prdata_ff <= `MCR_DATA_RESET;
            end
        end
    end

    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign prdata = prdata_ff;

    // Configuration registers written at the completing access edge.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < `MCR_CELLS; i++) begin
                cfg_ff[i] <= '0;
                exp_mask_ff[i] <= '0;
            end
            glb_ff <= '0;
            io_dir_ff <= 16'h0000;
            io_ce_ff <= 16'h0000;
        end else if (wr_take) begin
            if (bank == `MCR_BANK_CFG) begin
                cfg_ff[cell_idx] <= pwdata[`MCR_CFG_W-1:0];
            end else if (bank == `MCR_BANK_EXP) begin
                exp_mask_ff[cell_idx] <= pwdata[`MCR_EXP_TERMS-1:0];
            end else begin
                case (paddr)
                    `MCR_OFF_GLOBAL: glb_ff <= pwdata[`MCR_GLB_W-1:0];
                    `MCR_OFF_IO_DIR: io_dir_ff <= pwdata[15:0];
                    `MCR_OFF_IO_CE: io_ce_ff <= pwdata[15:0];
                    default: glb_ff <= glb_ff;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// ### mcr_lab_props.sv
/*
 Checker for the macrocell block: APB handshake and cell 15 preset and clear.
 Assumes it is bound to mcr_macrocell_lab; cell 15 config is tracked from APB writes.
*/
`default_nettype none
module mcr_lab_props (
    input wire logic clk, // Clock.
    input wire logic rst_n, // Reset, active low.
    input wire logic psel, // APB select.
    input wire logic penable, // APB enable.
    input wire logic pwrite, // APB direction.
    input wire logic [11:0] paddr, // APB address.
    input wire logic [31:0] pwdata, // APB write data.
    input wire logic [31:0] prdata, // APB read data.
    input wire logic pready, // APB ready.
    input wire logic pslverr, // APB error.
    input wire logic [15:0] preset_term, // Preset terms.
    input wire logic [15:0] clear_term, // Clear terms.
    input wire logic [15:0] reg_out // Registered outputs.
);
    logic [31:0] cfg15_ff;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg15_ff <= 32'h0000_0000;
        end else if (psel && penable && pready && pwrite && !pslverr && paddr == 12'h03C) begin
            cfg15_ff <= pwdata;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence access_s;
        pready ##1 !pready;
    endsequence
    apb_ready_a: assert property (setup_s |=> access_s) else $error("pready late");
    ready_pulse_a: assert property (pready |=> !pready) else $error("pready held");
    idle_data_a: assert property (!pready |-> prdata == 32'h0000_0000) else $error("prdata set");
    err_ready_a: assert property (pslverr |-> pready) else $error("pslverr alone");
    misaligned_err_a: assert property (setup_s ##0 paddr[1:0] != 2'h0 |=> pslverr)
        else $error("misaligned accepted");
    clear_wins_a: assert property (clear_term[15] && !cfg15_ff[2] |=> !reg_out[15])
        else $error("clear ignored");
    preset_sets_a: assert property (preset_term[15] && !clear_term[15] && !cfg15_ff[2]
        && !cfg15_ff[6] |=> reg_out[15]) else $error("preset ignored");
    reset_zero_a: assert property ($rose(rst_n) |-> reg_out == 16'h0000) else $error("not reset");
endmodule
bind mcr_macrocell_lab mcr_lab_props props_u (.clk, .rst_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .preset_term, .clear_term, .reg_out);
`default_nettype wire

// ### mcr_array_model.sv
/*
 Model of the product-term array and dedicated pins that feed the block.
 Assumes the bench sets its outputs directly and calls pulse_clock after a rising edge.
*/
`default_nettype none
module mcr_array_model (
    input wire logic clk, // System clock.
    output logic global_clock_pin_a, // Clock pin A.
    output logic global_clock_pin_b, // Clock pin B.
    output logic global_clear_pin, // Clear pin.
    output logic global_ctrl_pin_d, // Fourth pin.
    output logic [79:0] product_terms, // Terms.
    output logic [26:0] expander_terms, // Expanders.
    output logic [15:0] array_clock_term, // Array clocks.
    output logic [15:0] clock_enable_term, // Enables.
    output logic [15:0] preset_term, // Presets.
    output logic [15:0] clear_term, // Clears.
    output logic [15:0] io_data_in // I/O pins.
);
    initial begin
        global_clock_pin_a = 1'b0;
        global_clock_pin_b = 1'b0;
        global_clear_pin = 1'b1;
        global_ctrl_pin_d = 1'b0;
        product_terms = '0;
        expander_terms = '0;
        array_clock_term = '0;
        clock_enable_term = '0;
        preset_term = '0;
        clear_term = '0;
        io_data_in = '0;
    end
    // Pulses stay high for several clocks so the block's synchronisers see them.
    task automatic pulse_clock(input logic [1:0] which);
        begin
            @(posedge clk);
            if (which == 2'h0) global_clock_pin_a <= 1'b1;
            else if (which == 2'h1) global_clock_pin_b <= 1'b1;
            else array_clock_term[0] <= 1'b1;
            repeat (4) @(posedge clk);
            global_clock_pin_a <= 1'b0;
            global_clock_pin_b <= 1'b0;
            array_clock_term[0] <= 1'b0;
            repeat (5) @(posedge clk);
        end
    endtask
endmodule
`default_nettype wire

// ### configurable_macrocell_register_test.sv
/*
 Self-checking bench for the macrocell block: a table of cell 0 cases, then hand tests.
 Assumes mcr_array_model drives the array side and APB is driven here.
*/
`default_nettype none
module configurable_macrocell_register_test;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [10:0] cfg;
        logic init;
        logic [4:0] terms;
        logic en;
        logic [1:0] src;
        logic [1:0] pulses;
        logic exp;
    } mcr_row_type;
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic global_clock_pin_a, global_clock_pin_b, global_clear_pin, global_ctrl_pin_d, er;
    logic [79:0] product_terms;
    logic [26:0] expander_terms;
    logic [15:0] array_clock_term, clock_enable_term, preset_term, clear_term, io_data_in;
    logic [15:0] reg_out, comb_out, global_route_out, logic_array_block_out, io_reg_out;
    int err_total = 0;
    int num_checks = 0;
    int cycles = 0;
    mcr_row_type rows [16] = '{
        '{11'h000, 1'h0, 5'h01, 1'h0, 2'h0, 2'h1, 1'h1}, '{11'h000, 1'h1, 5'h00, 1'h0, 2'h0, 2'h1, 1'h0},
        '{11'h001, 1'h0, 5'h01, 1'h0, 2'h0, 2'h3, 1'h1}, '{11'h001, 1'h1, 5'h01, 1'h0, 2'h0, 2'h2, 1'h1},
        '{11'h002, 1'h0, 5'h01, 1'h0, 2'h0, 2'h1, 1'h1}, '{11'h002, 1'h1, 5'h03, 1'h0, 2'h0, 2'h1, 1'h0},
        '{11'h002, 1'h1, 5'h02, 1'h0, 2'h0, 2'h1, 1'h0}, '{11'h002, 1'h1, 5'h00, 1'h0, 2'h0, 2'h1, 1'h1},
        '{11'h003, 1'h0, 5'h01, 1'h0, 2'h0, 2'h1, 1'h1}, '{11'h003, 1'h1, 5'h02, 1'h0, 2'h0, 2'h1, 1'h0},
        '{11'h003, 1'h1, 5'h03, 1'h0, 2'h0, 2'h1, 1'h0}, '{11'h008, 1'h0, 5'h01, 1'h0, 2'h0, 2'h1, 1'h0},
        '{11'h008, 1'h0, 5'h01, 1'h1, 2'h0, 2'h1, 1'h1}, '{11'h010, 1'h0, 5'h01, 1'h0, 2'h0, 2'h1, 1'h0},
        '{11'h010, 1'h0, 5'h01, 1'h0, 2'h2, 2'h1, 1'h1}, '{11'h004, 1'h0, 5'h01, 1'h0, 2'h0, 2'h0, 1'h1}};
    mcr_macrocell_lab dut_u (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .global_clock_pin_a, .global_clock_pin_b, .global_clear_pin,
        .global_ctrl_pin_d, .product_terms, .expander_terms, .array_clock_term, .clock_enable_term,
        .preset_term, .clear_term, .io_data_in, .reg_out, .comb_out, .global_route_out,
        .logic_array_block_out, .io_reg_out);
    mcr_array_model model_u (.clk, .global_clock_pin_a, .global_clock_pin_b, .global_clear_pin,
        .global_ctrl_pin_d, .product_terms, .expander_terms, .array_clock_term, .clock_enable_term,
        .preset_term, .clear_term, .io_data_in);
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            end_sim();
        end
    end
    task automatic cmp_bit(input string name, input logic exp, input logic got);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %b seen %b", name, exp, got);
        end
    endtask
    task automatic cmp_word(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    // Read data and error are taken in the access cycle, then the request is released.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) begin
            @(posedge clk);
            n++;
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        cmp_word("wait states", 32'h0000_0000, n);
    endtask
    task automatic set_q(input int c, input logic v);
        @(posedge clk);
        model_u.preset_term[c] <= v;
        model_u.clear_term[c] <= !v;
        repeat (2) @(posedge clk);
        model_u.preset_term[c] <= 1'b0;
        model_u.clear_term[c] <= 1'b0;
    endtask
    task automatic settle();
        repeat (5) @(posedge clk);
        @(negedge clk);
    endtask
    initial begin
        rst_n = 1'b0;
        {psel, penable, pwrite} = 3'h0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        apb(1'b0, 12'h000, 32'h0000_0000);
        cmp_word("cfg0 reset", 32'h0000_0000, rd);
        apb(1'b0, 12'h100, 32'h0000_0000);
        cmp_word("global reset", 32'h0000_0000, rd);
        cmp_word("reg_out reset", 32'h0000_0000, {16'h0000, reg_out});
        foreach (rows[i]) begin
            apb(1'b1, 12'h000, {21'h00_0000, rows[i].cfg});
            model_u.product_terms[4:0] <= 5'h00;
            model_u.clock_enable_term[0] <= rows[i].en;
            set_q(0, rows[i].init);
            model_u.product_terms[4:0] <= rows[i].terms;
            repeat (rows[i].pulses) model_u.pulse_clock(rows[i].src);
            settle();
            cmp_bit("reg_out0", rows[i].exp, reg_out[0]);
            $display("row %0d done", i);
        end
        apb(1'b1, 12'h100, 32'h0000_002A);
        apb(1'b0, 12'h100, 32'h0000_0000);
        cmp_word("global rw", 32'h0000_002A, rd);
        apb(1'b1, 12'h102, 32'h0000_0000);
        cmp_bit("misaligned err", 1'b1, er);
        apb(1'b0, 12'h200, 32'h0000_0000);
        cmp_bit("unmapped err", 1'b1, er);
        cmp_word("unmapped data", 32'h0000_0000, rd);
        $display("apb test done");
        apb(1'b1, 12'h000, 32'h0000_0000);
        apb(1'b1, 12'h100, 32'h0000_0001);
        set_q(0, 1'b0);
        model_u.product_terms[4:0] <= 5'h01;
        model_u.pulse_clock(2'h0);
        cmp_bit("pin a unused", 1'b0, reg_out[0]);
        model_u.pulse_clock(2'h1);
        cmp_bit("pin b clocks", 1'b1, reg_out[0]);
        apb(1'b1, 12'h100, 32'h0000_0000);
        $display("clock select test done");
        model_u.preset_term[15] <= 1'b1;
        model_u.clear_term[15] <= 1'b1;
        settle();
        cmp_bit("clear wins", 1'b0, reg_out[15]);
        model_u.clear_term[15] <= 1'b0;
        settle();
        cmp_bit("preset", 1'b1, reg_out[15]);
        model_u.preset_term[15] <= 1'b0;
        apb(1'b0, 12'h104, 32'h0000_0000);
        cmp_bit("regstate15", 1'b1, rd[15]);
        $display("preset clear test done");
        model_u.global_clear_pin <= 1'b0;
        apb(1'b1, 12'h004, 32'h0000_0040);
        apb(1'b1, 12'h100, 32'h0000_0010);
        set_q(1, 1'b1);
        settle();
        cmp_bit("high clear idle", 1'b1, reg_out[1]);
        model_u.global_clear_pin <= 1'b1;
        settle();
        cmp_bit("high clear", 1'b0, reg_out[1]);
        apb(1'b1, 12'h100, 32'h0000_0000);
        set_q(1, 1'b1);
        settle();
        cmp_bit("low clear idle", 1'b1, reg_out[1]);
        model_u.global_clear_pin <= 1'b0;
        settle();
        cmp_bit("low clear", 1'b0, reg_out[1]);
        model_u.global_clear_pin <= 1'b1;
        $display("global clear test done");
        apb(1'b1, 12'h000, 32'h0000_0180);
        set_q(0, 1'b0);
        model_u.product_terms[4:0] <= 5'h02;
        model_u.pulse_clock(2'h0);
        cmp_bit("packed reg", 1'b0, reg_out[0]);
        cmp_bit("packed comb", 1'b1, comb_out[0]);
        cmp_bit("global route comb", 1'b1, global_route_out[0]);
        cmp_bit("local route reg", 1'b0, logic_array_block_out[0]);
        $display("packing test done");
        apb(1'b1, 12'h110, 32'h0000_0000);
        apb(1'b1, 12'h114, 32'h0000_0001);
        model_u.io_data_in[0] <= 1'b1;
        model_u.pulse_clock(2'h0);
        cmp_bit("io register", 1'b1, io_reg_out[0]);
        apb(1'b1, 12'h100, 32'h0000_0020);
        model_u.io_data_in[0] <= 1'b0;
        model_u.pulse_clock(2'h0);
        cmp_bit("io gated", 1'b1, io_reg_out[0]);
        $display("io test done");
        apb(1'b1, 12'h080, 32'h0000_0001);
        model_u.product_terms[4:0] <= 5'h10;
        settle();
        cmp_bit("fifth term", 1'b1, comb_out[0]);
        apb(1'b1, 12'h000, 32'h0000_0600);
        model_u.product_terms[4:0] <= 5'h00;
        model_u.expander_terms[0] <= 1'b1;
        settle();
        cmp_bit("expander", 1'b1, comb_out[0]);
        cmp_bit("local route comb", 1'b1, logic_array_block_out[0]);
        $display("expander test done");
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        cmp_word("mid reset outs", 32'h0000_0000, {reg_out, io_reg_out});
        rst_n <= 1'b1;
        apb(1'b0, 12'h000, 32'h0000_0000);
        cmp_word("cfg0 mid reset", 32'h0000_0000, rd);
        $display("reset test done");
        end_sim();
    end
endmodule
`default_nettype wire
